//--- design/pll_gate_defines.svh
// Register offsets, field positions, reset values and timing values in ns
`ifndef PLL_GATE_DEFINES_SVH
`define PLL_GATE_DEFINES_SVH

`define CTRL_A_OFFSET     8'h00
`define CTRL_B_OFFSET     8'h04
`define STATUS_OFFSET     8'h08
`define INT_STATUS_OFFSET 8'h0C
`define INT_MASK_OFFSET   8'h10

`define CTRL_A_ENABLE_BIT    1
`define CTRL_A_ON_REQ_BIT    7
`define CTRL_B_BYPASS_BIT    12
`define STATUS_LOCK_BIT      0
`define STATUS_READY_BIT     1

`define INT_LOCK_RISE_BIT    0
`define INT_LOCK_FALL_BIT    1
`define INT_READY_BIT        2

`define CTRL_A_RESET   32'h0000_0080
`define CTRL_B_RESET   32'h0000_0000
`define INT_MASK_RESET 3'h0

// Start-up wait before the output counts as ready, in ns
`define READY_DELAY_NS     1000
`define CLK_PERIOD_NS      100

`endif

//--- design/pll_gate_pkg.sv
// Types shared by the PLL lock and gating control block
`default_nettype none
package pll_gate_pkg;
    typedef enum logic [1:0] {
        RESP_OKAY   = 2'b00,
        RESP_SLVERR = 2'b10
    } axi_resp_t;

    typedef enum logic [2:0] {
        RUN_OFF   = 3'b001,
        RUN_START = 3'b010,
        RUN_READY = 3'b100
    } run_state_t;
endpackage
`default_nettype wire

//--- design/pll_gate_if.sv
// Control and state links between register file and run sequencer
`default_nettype none
interface pll_gate_if;
    logic enable;
    logic on_request;
    logic bypass;
    logic locked;
    logic ready;
    logic running;
    logic gate_open;

    modport regs (output enable, output on_request, output bypass,
                  input locked, input ready, input running,
                  input gate_open);
    modport seq  (input enable, input on_request, input bypass,
                  input locked, output ready, output running,
                  output gate_open);
endinterface
`default_nettype wire

//--- design/pll_run_seq.sv
// Run sequencer: enable, on-request and ready timing; standby is unused
`include "pll_gate_defines.svh"
`default_nettype none
module pll_run_seq
    import pll_gate_pkg::*;
#(
    parameter int READY_CYCLES =
        (`READY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic i_clk_sys,
    input  wire logic i_rst_n,
    input  wire logic i_clk_request,
    input  wire logic i_standby,
    pll_gate_if.seq   link
);
    localparam int CW = $clog2(READY_CYCLES + 1);

    run_state_t     state_q;
    run_state_t     state_d;
    logic [CW-1:0]  count_q;
    logic           want_run;
    logic           count_done;

    // Continuous running ignores standby when on-request is off
    assign want_run = link.enable &&
        (link.on_request ? i_clk_request : 1'b1);
    assign count_done = (count_q == CW'(READY_CYCLES - 1));
    assign link.running   = (state_q != RUN_OFF);
    assign link.ready     = (state_q == RUN_READY);
    // Lock gates the output only while bypass is off
    assign link.gate_open = (state_q == RUN_READY) &&
        (link.bypass || link.locked);

    always_comb begin
        state_d = state_q;
        case (state_q)
            RUN_OFF:   if (want_run) state_d = RUN_START;
            RUN_START: begin
                if (!want_run)       state_d = RUN_OFF;
                else if (count_done) state_d = RUN_READY;
            end
            RUN_READY: if (!want_run) state_d = RUN_OFF;
            default:   state_d = RUN_OFF;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state_q <= RUN_OFF;
            count_q <= '0;
        end else begin
            state_q <= state_d;
            count_q <= (state_q == RUN_START) ? count_q + CW'(1) : '0;
        end
    end

    // Standby has no effect on the run request; it is left unused
    logic unused_standby;
    assign unused_standby = i_standby;
endmodule
`default_nettype wire

//--- design/pll_lock_gating_control.sv
// PLL lock status, output gating and AXI4-Lite register file
`include "pll_gate_defines.svh"
`default_nettype none

module pll_lock_gating_control
    import pll_gate_pkg::*;
#(
    parameter int READY_CYCLES =
        (`READY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS
) (
    input  wire logic        i_clk_sys,
    input  wire logic        i_rst_n,
    input  wire logic        i_pll_locked,
    input  wire logic        i_clk_request,
    input  wire logic        i_standby,
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output var  logic        s_axi_awready,
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output var  logic        s_axi_wready,
    output var  logic [1:0]  s_axi_bresp,
    output var  logic        s_axi_bvalid,
    input  wire logic        s_axi_bready,
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output var  logic        s_axi_arready,
    output var  logic [31:0] s_axi_rdata,
    output var  logic [1:0]  s_axi_rresp,
    output var  logic        s_axi_rvalid,
    input  wire logic        s_axi_rready,
    output var  logic        o_pll_run,
    output var  logic        o_clk_gate_en,
    output var  logic        o_irq
);
    pll_gate_if link ();

    // ----------------------------------------------------------------
    // Register state
    // ----------------------------------------------------------------
    logic [31:0] ctrl_a_q;
    logic [31:0] ctrl_b_q;
    logic [2:0]  int_stat_q;
    logic [2:0]  int_stat_d;
    logic [2:0]  int_mask_q;
    logic        locked_q;
    logic        ready_q;
    logic [2:0]  events;

    assign link.enable     = ctrl_a_q[`CTRL_A_ENABLE_BIT];
    assign link.on_request = ctrl_a_q[`CTRL_A_ON_REQ_BIT];
    assign link.bypass     = ctrl_b_q[`CTRL_B_BYPASS_BIT];
    // Lock seen only while running; bypass is not an input here
    assign link.locked     = i_pll_locked && link.running;

    pll_run_seq #(
        .READY_CYCLES (READY_CYCLES)
    ) u_seq (
        .i_clk_sys     (i_clk_sys),
        .i_rst_n       (i_rst_n),
        .i_clk_request (i_clk_request),
        .i_standby     (i_standby),
        .link          (link)
    );

    // ----------------------------------------------------------------
    // AXI4-Lite write path
    // ----------------------------------------------------------------
    logic [7:0]  aw_q;
    logic        aw_have_q;
    logic [31:0] w_q;
    logic [3:0]  ws_q;
    logic        w_have_q;
    logic        do_write;
    logic        wr_ok;

    function automatic logic [31:0] merge(input logic [31:0] old,
                                          input logic [31:0] nw,
                                          input logic [3:0]  st);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++)
            if (st[i]) r[i*8 +: 8] = nw[i*8 +: 8];
        return r;
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        return a == `CTRL_A_OFFSET || a == `CTRL_B_OFFSET ||
               a == `STATUS_OFFSET || a == `INT_STATUS_OFFSET ||
               a == `INT_MASK_OFFSET;
    endfunction

    assign do_write = aw_have_q && w_have_q && !s_axi_bvalid;
    assign wr_ok    = mapped(aw_q);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            aw_q          <= 8'h00;
            aw_have_q     <= 1'b0;
            w_q           <= 32'h0000_0000;
            ws_q          <= 4'h0;
            w_have_q      <= 1'b0;
            s_axi_awready <= 1'b0;
            s_axi_wready  <= 1'b0;
            s_axi_bvalid  <= 1'b0;
            s_axi_bresp   <= RESP_OKAY;
        end else begin
            s_axi_awready <= !aw_have_q && !s_axi_awready && s_axi_awvalid;
            s_axi_wready  <= !w_have_q && !s_axi_wready && s_axi_wvalid;
            if (s_axi_awvalid && s_axi_awready) begin
                aw_q      <= s_axi_awaddr;
                aw_have_q <= 1'b1;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                w_q      <= s_axi_wdata;
                ws_q     <= s_axi_wstrb;
                w_have_q <= 1'b1;
            end
            if (do_write) begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? RESP_OKAY : RESP_SLVERR;
                aw_have_q    <= 1'b0;
                w_have_q     <= 1'b0;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Control registers
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ctrl_a_q   <= `CTRL_A_RESET;
            ctrl_b_q   <= `CTRL_B_RESET;
            int_mask_q <= `INT_MASK_RESET;
        end else if (do_write) begin
            if (aw_q == `CTRL_A_OFFSET)
                ctrl_a_q <= merge(ctrl_a_q, w_q, ws_q);
            if (aw_q == `CTRL_B_OFFSET)
                ctrl_b_q <= merge(ctrl_b_q, w_q, ws_q);
            if (aw_q == `INT_MASK_OFFSET && ws_q[0])
                int_mask_q <= w_q[2:0];
        end
    end

    // ----------------------------------------------------------------
    // Status, events and interrupt
    // ----------------------------------------------------------------
    logic        rd_fire;
    logic        rd_clear;
    logic [31:0] rd_word;
    logic [31:0] status_word;

    assign rd_fire  = s_axi_arvalid && s_axi_arready;
    assign rd_clear = rd_fire && (s_axi_araddr == `INT_STATUS_OFFSET);
    assign events[`INT_LOCK_RISE_BIT] = link.locked && !locked_q;
    assign events[`INT_LOCK_FALL_BIT] = !link.locked && locked_q;
    assign events[`INT_READY_BIT]     = link.ready && !ready_q;
    // A new event in the clearing read's cycle survives
    assign int_stat_d = (rd_clear ? 3'h0 : int_stat_q) | events;

    always_comb begin
        status_word = 32'h0000_0000;
        status_word[`STATUS_LOCK_BIT]  = locked_q;
        status_word[`STATUS_READY_BIT] = ready_q;
    end

    always_comb begin
        case (s_axi_araddr)
            `CTRL_A_OFFSET:     rd_word = ctrl_a_q;
            `CTRL_B_OFFSET:     rd_word = ctrl_b_q;
            `STATUS_OFFSET:     rd_word = status_word;
            `INT_STATUS_OFFSET: rd_word = {29'h0, int_stat_q};
            `INT_MASK_OFFSET:   rd_word = {29'h0, int_mask_q};
            default:            rd_word = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            locked_q      <= 1'b0;
            ready_q       <= 1'b0;
            int_stat_q    <= 3'h0;
            o_irq         <= 1'b0;
            o_pll_run     <= 1'b0;
            o_clk_gate_en <= 1'b0;
        end else begin
            locked_q      <= link.locked;
            ready_q       <= link.ready;
            int_stat_q    <= int_stat_d;
            o_irq         <= |(int_stat_d & int_mask_q);
            o_pll_run     <= link.running;
            o_clk_gate_en <= link.gate_open;
        end
    end

    // ----------------------------------------------------------------
    // AXI4-Lite read path
    // ----------------------------------------------------------------
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else begin
            s_axi_arready <= !s_axi_rvalid && !s_axi_arready &&
                             s_axi_arvalid;
            if (rd_fire) begin
                s_axi_rvalid <= 1'b1;
                s_axi_rdata  <= rd_word;
                s_axi_rresp  <= mapped(s_axi_araddr) ? RESP_OKAY
                                                     : RESP_SLVERR;
            end else if (s_axi_rvalid && s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

//--- dv/pll_gate_checker.sv
// Port-level assertions for the PLL lock gating control block
`include "pll_gate_defines.svh"
`default_nettype none
module pll_gate_checker #(
    parameter int READY_CYCLES = 10
) (
    input wire logic        i_clk_sys,
    input wire logic        i_rst_n,
    input wire logic        i_pll_locked,
    input wire logic [7:0]  s_axi_awaddr,
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic        o_pll_run,
    input wire logic        o_clk_gate_en
);
    timeunit 1ns;
    timeprecision 1ns;
    // ------
    // Bypass shadow
    // ------
    // Lags the real bit by a cycle; properties tolerate the skew
    logic [7:0]  adr_q;
    logic [31:0] dat_q;
    logic        byp_q;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            byp_q <= 1'b0;
        end else begin
            if (s_axi_awvalid && s_axi_awready) adr_q <= s_axi_awaddr;
            if (s_axi_wvalid && s_axi_wready) dat_q <= s_axi_wdata;
            if ($rose(s_axi_bvalid) && adr_q == `CTRL_B_OFFSET)
                byp_q <= dat_q[`CTRL_B_BYPASS_BIT];
        end
    end
    // ------
    // Run history
    // ------
    // Cleared whenever the loop stops, so a restart is judged afresh
    logic open_q;
    int   run_cnt_q;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || !o_pll_run) begin
            open_q    <= 1'b0;
            run_cnt_q <= 0;
        end else begin
            if (o_clk_gate_en) open_q <= 1'b1;
            if (run_cnt_q < READY_CYCLES) run_cnt_q <= run_cnt_q + 1;
        end
    end
    // ------
    // Properties
    // ------
    default clocking cb @(posedge i_clk_sys); endclocking
    default disable iff (!i_rst_n);
    sequence s_unlocked2;
        (!i_pll_locked && !byp_q) [*2];
    endsequence
    sequence s_relock3;
        (o_pll_run && i_pll_locked) [*3];
    endsequence
    sequence s_byp_run;
        (byp_q && o_clk_gate_en) ##1 (byp_q && o_pll_run);
    endsequence
    AST_RESET_QUIET: assert property ($rose(i_rst_n) |-> !o_clk_gate_en)
        else $error("gate open at reset release");
    AST_GATE_NEEDS_RUN: assert property (o_clk_gate_en |-> o_pll_run)
        else $error("gate open without pll running");
    AST_GATE_AFTER_START: assert property (
        $rose(o_clk_gate_en) |-> $past(o_pll_run, 2))
        else $error("gate opened before start delay");
    AST_UNLOCK_STOPS: assert property (s_unlocked2 |=> !o_clk_gate_en)
        else $error("gate open while unlocked");
    AST_RELOCK_RESUMES: assert property (
        (!byp_q && open_q && o_pll_run && $rose(i_pll_locked))
        ##1 s_relock3 |-> o_clk_gate_en)
        else $error("gate did not resume on lock");
    AST_READY_WAIT: assert property (
        $rose(o_clk_gate_en) |-> run_cnt_q >= READY_CYCLES)
        else $error("gate opened before ready delay");
    AST_BYPASS_KEEPS: assert property (s_byp_run |-> o_clk_gate_en)
        else $error("gate closed under bypass");
    AST_BVALID_HOLDS: assert property (
        s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
        else $error("bvalid dropped early");
    AST_RVALID_HOLDS: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read answer changed early");
    AST_READ_ANSWER: assert property (
        $rose(s_axi_rvalid) |-> $past(s_axi_arvalid && s_axi_arready))
        else $error("rvalid without address handshake");
endmodule
`default_nettype wire

//--- dv/tb_pll_lock_gating_control.sv
// Self-checking bench for the PLL lock gating control block
`include "pll_gate_defines.svh"
`default_nettype none
`define CHK(g, e) chk(g, e)
bind pll_lock_gating_control pll_gate_checker
    #(.READY_CYCLES(READY_CYCLES)) chk_i (.*);
module tb_pll_lock_gating_control;
    timeunit 1ns;
    timeprecision 1ns;
    import pll_gate_pkg::*;
    localparam int RC = 2;
    logic        i_clk_sys = 1'b0;
    logic        i_rst_n, i_pll_locked, i_clk_request, i_standby;
    logic [7:0]  s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, d;
    logic [3:0]  s_axi_wstrb;
    logic [1:0]  s_axi_bresp, s_axi_rresp, r;
    logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic        s_axi_rvalid, s_axi_rready, o_pll_run, o_clk_gate_en, o_irq;
    int          error_cnt = 0;
    int          compares = 0;
    always #50 i_clk_sys = ~i_clk_sys;
    pll_lock_gating_control #(.READY_CYCLES(RC)) DUT (.*);
    // ------
    // Tasks
    // ------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        compares++;
        if (g !== e) begin
            error_cnt++;
            $display("wrong value at %0t: %h, expected %h", $time, g, e);
        end
    endtask
    task automatic final_report();
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask
    task automatic timeout();
        error_cnt++;
        final_report();
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge i_clk_sys);
    endtask
    // Hold h delays the response ready to exercise master back-pressure
    task automatic wr(input logic [7:0] a, input logic [31:0] v, input int h);
        int n;
        @(posedge i_clk_sys);
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= (h == 0);
        for (n = 0; n < 60; n++) begin
            @(posedge i_clk_sys);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            if (s_axi_bvalid && s_axi_bready) break;
            s_axi_bready <= (n >= h);
        end
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
        if (n == 60) timeout();
    endtask
    task automatic rd(input logic [7:0] a, input int h);
        int n;
        @(posedge i_clk_sys);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= (h == 0);
        for (n = 0; n < 60; n++) begin
            @(posedge i_clk_sys);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            if (s_axi_rvalid && s_axi_rready) break;
            s_axi_rready <= (n >= h);
        end
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
        if (n == 60) timeout();
    endtask
    // ------
    // Scenarios
    // ------
    initial begin
        int k;
        i_rst_n <= 1'b0;
        i_pll_locked <= 1'b1;
        i_clk_request <= 1'b0;
        i_standby <= 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_wvalid <= 1'b0;
        s_axi_bready <= 1'b0;
        s_axi_arvalid <= 1'b0;
        s_axi_rready <= 1'b0;
        s_axi_awaddr <= 8'h00;
        s_axi_araddr <= 8'h00;
        s_axi_wdata <= 32'h0;
        s_axi_wstrb <= 4'hF;
        tick(20);
        i_rst_n <= 1'b1;
        for (k = 0; k < 5; k++) begin
            rd(8'(k * 4), k);
            `CHK(d, (k == 0) ? `CTRL_A_RESET : 32'h0);
        end
        rd(8'h14, 0);
        `CHK(d, 32'h0);
        `CHK(r, RESP_SLVERR);
        wr(`CTRL_A_OFFSET, 32'h82, 0);
        tick(6);
        `CHK(o_pll_run, 1'b0);
        i_clk_request <= 1'b1;
        tick(10);
        `CHK(o_pll_run, 1'b1);
        `CHK(o_clk_gate_en, 1'b1);
        i_clk_request <= 1'b0;
        tick(5);
        `CHK(o_pll_run, 1'b0);
        `CHK(o_clk_gate_en, 1'b0);
        wr(`CTRL_A_OFFSET, 32'h02, 0);
        i_standby <= 1'b1;
        tick(10);
        `CHK(o_pll_run, 1'b1);
        rd(`STATUS_OFFSET, 0);
        `CHK(d, 32'h3);
        `CHK(o_irq, 1'b0);
        wr(`INT_MASK_OFFSET, 32'h7, 0);
        tick(3);
        `CHK(o_irq, 1'b1);
        rd(`INT_STATUS_OFFSET, 0);
        `CHK(d, 32'h7);
        tick(3);
        `CHK(o_irq, 1'b0);
        i_pll_locked <= 1'b0;
        tick(5);
        `CHK(o_clk_gate_en, 1'b0);
        `CHK(o_irq, 1'b1);
        rd(`STATUS_OFFSET, 0);
        `CHK(d, 32'h2);
        rd(`INT_STATUS_OFFSET, 0);
        `CHK(d, 32'h2);
        i_pll_locked <= 1'b1;
        tick(5);
        `CHK(o_clk_gate_en, 1'b1);
        rd(`INT_STATUS_OFFSET, 0);
        `CHK(d, 32'h1);
        wr(`CTRL_B_OFFSET, 32'h1000, 6);
        i_pll_locked <= 1'b0;
        tick(6);
        `CHK(o_clk_gate_en, 1'b1);
        rd(`STATUS_OFFSET, 0);
        `CHK(d, 32'h2);
        i_pll_locked <= 1'b1;
        wr(`CTRL_A_OFFSET, 32'h0, 0);
        tick(5);
        rd(`STATUS_OFFSET, 0);
        `CHK(d, 32'h0);
        `CHK(o_clk_gate_en, 1'b0);
        wr(`CTRL_B_OFFSET, 32'h1000, 0);
        wr(`CTRL_A_OFFSET, 32'h02, 0);
        for (k = 0; k < 40; k++) begin
            rd(`STATUS_OFFSET, 0);
            if (d[1] === 1'b1) break;
        end
        if (k == 40) timeout();
        `CHK(d, 32'h3);
        tick(2);
        `CHK(o_clk_gate_en, 1'b1);
        wr(`STATUS_OFFSET, 32'h0, 0);
        `CHK(r, RESP_OKAY);
        wr(8'h14, 32'h0, 0);
        `CHK(r, RESP_SLVERR);
        rd(`STATUS_OFFSET, 0);
        `CHK(d, 32'h3);
        s_axi_wstrb <= 4'hE;
        wr(`CTRL_A_OFFSET, 32'h0, 0);
        rd(`CTRL_A_OFFSET, 0);
        `CHK(d, 32'h2);
        `CHK(o_pll_run, 1'b1);
        final_report();
    end
endmodule
`default_nettype wire
